/* File: hw/mcei_pkg.sv */
// Purpose: constants and types for the memory controller event interrupts
// Assumes: 32-bit APB register access, one clock
// Notes:   bit order of every status vector follows the src_* indices
package mcei_pkg;

  // event sources, bit positions in every status vector
  localparam int SRC_N        = 10;
  localparam int SRC_RAM_C    = 0;
  localparam int SRC_RAM_D    = 1;
  localparam int SRC_DRAM_C   = 2;
  localparam int SRC_DRAM_D   = 3;
  localparam int SRC_ACCESS   = 4;
  localparam int SRC_PROG     = 5;
  localparam int SRC_LINK     = 6;
  localparam int SRC_TEMP     = 7;
  localparam int SRC_ARCH     = 8;
  localparam int SRC_PHY      = 9;

  localparam int ARCH_W       = 4;

  // register byte offsets
  localparam logic [11:0] OFF_INT_STATUS = 12'h000;
  localparam logic [11:0] OFF_OFL_STATUS = 12'h004;
  localparam logic [11:0] OFF_INT_MASK   = 12'h008;
  localparam logic [11:0] OFF_ARCH_STATE = 12'h00C;

  // reset values
  localparam logic [SRC_N-1:0]  RST_STATUS = 10'h000;
  localparam logic [SRC_N-1:0]  RST_MASK   = 10'h000;
  localparam logic [ARCH_W-1:0] RST_ARCH   = 4'h0;
  localparam logic [31:0]       RST_RDATA  = 32'h0000_0000;

  // event strobes from the controller core, one-cycle pulses
  typedef struct packed {
    logic ram_corr;
    logic ram_uncorr;
    logic dram_corr;
    logic dram_uncorr;
    logic access_fail;
    logic prog_fail;
    logic link_fail;
    logic temp_direct;
    logic temp_poll;
    logic phy_req;
  } mcei_event_type;

  // apb request side
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mcei_apb_req_type;

endpackage

/* File: hw/mcei_flag_cell.sv */
// Purpose: one sticky interrupt flag with its overflow flag
// Assumes: clear inputs are one-cycle write-one-to-clear strobes
// Notes:   a set in the clearing cycle wins over the clear
`timescale 1ns/100ps
`default_nettype none
module mcei_flag_cell (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // event and clears
  input  wire logic event_i,
  input  wire logic clr_int,
  input  wire logic clr_ofl,
  // flags
  output var  logic int_d,
  output var  logic int_q,
  output var  logic ofl_d,
  output var  logic ofl_q
);

  always_comb begin
    // held until cleared, event wins over clear
    int_d = event_i | (int_q & ~clr_int);
  end

  always_comb begin
    // recurrence while the earlier one still stands
    // cleared only by software, never by more events
    ofl_d = (event_i & int_q & ~clr_int) | (ofl_q & ~clr_ofl);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_q <= 1'b0;
    end else begin
      int_q <= int_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ofl_q <= 1'b0;
    end else begin
      ofl_q <= ofl_d;
    end
  end

endmodule // mcei_flag_cell
`default_nettype wire

/* File: hw/mcei_top.sv */
// Purpose: event interrupt and overflow signalling of a memory controller
// Assumes: event strobes are synchronous one-cycle pulses on pclk
// Notes:   apb answers one cycle into the access phase
`timescale 1ns/100ps
`default_nettype none

module mcei_top (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output var  logic [31:0]             prdata,
  output var  logic                    pready,
  output var  logic                    pslverr,
  // event sources
  input  wire mcei_pkg::mcei_event_type events,
  input  wire logic [mcei_pkg::ARCH_W-1:0] arch_state,
  // interrupt outputs
  output var  logic                    ram_ecc_errc_int,
  output var  logic                    ram_ecc_errd_int,
  output var  logic                    dram_ecc_errc_int,
  output var  logic                    dram_ecc_errd_int,
  output var  logic                    failed_access_int,
  output var  logic                    failed_prog_int,
  output var  logic                    link_err_int,
  output var  logic                    temperature_event_int,
  output var  logic                    arch_fsm_int,
  output var  logic                    phy_request_int,
  output var  logic                    combined_int,
  // overflow outputs
  output var  logic                    ram_ecc_errc_oflow,
  output var  logic                    ram_ecc_errd_oflow,
  output var  logic                    dram_ecc_errc_oflow,
  output var  logic                    dram_ecc_errd_oflow,
  output var  logic                    failed_access_oflow,
  output var  logic                    failed_prog_oflow,
  output var  logic                    link_err_oflow,
  output var  logic                    temperature_event_oflow,
  output var  logic                    arch_fsm_oflow,
  output var  logic                    phy_request_oflow,
  output var  logic                    combined_oflow,
  // masked summary interrupt
  output var  logic                    irq
);

  localparam int N = mcei_pkg::SRC_N;

  mcei_pkg::mcei_apb_req_type req;
  logic [N-1:0]                  ev;
  logic [N-1:0]                  int_d;
  logic [N-1:0]                  int_q;
  logic [N-1:0]                  ofl_d;
  logic [N-1:0]                  ofl_q;
  logic [N-1:0]                  clr_int;
  logic [N-1:0]                  clr_ofl;
  logic [N-1:0]                  mask_q;
  logic [mcei_pkg::ARCH_W-1:0]   arch_q;
  logic                          arch_valid_q;
  logic                          arch_chg;
  logic                          pready_q;
  logic                          pslverr_q;
  logic [31:0]                   prdata_q;
  logic                          comb_int_q;
  logic                          comb_ofl_q;
  logic                          irq_q;
  logic                          acc;
  logic                          wr_fire;
  logic                          hit;
  logic [31:0]                   rd_mux;

  assign req.psel    = psel;
  assign req.penable = penable;
  assign req.pwrite  = pwrite;
  assign req.paddr   = paddr;
  assign req.pwdata  = pwdata;

  // event collection

  // the first sample after reset only arms the detector, so a nonzero
  // state at release is not mistaken for a change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arch_q       <= mcei_pkg::RST_ARCH;
      arch_valid_q <= 1'b0;
    end else begin
      arch_q       <= arch_state;
      arch_valid_q <= 1'b1;
    end
  end

  assign arch_chg = arch_valid_q & (arch_state != arch_q);

  always_comb begin
    ev = '0;
    ev[mcei_pkg::SRC_RAM_C]  = events.ram_corr;
    ev[mcei_pkg::SRC_RAM_D]  = events.ram_uncorr;
    ev[mcei_pkg::SRC_DRAM_C] = events.dram_corr;
    ev[mcei_pkg::SRC_DRAM_D] = events.dram_uncorr;
    ev[mcei_pkg::SRC_ACCESS] = events.access_fail;
    ev[mcei_pkg::SRC_PROG]   = events.prog_fail;
    ev[mcei_pkg::SRC_LINK]   = events.link_fail;
    ev[mcei_pkg::SRC_TEMP]   = events.temp_direct
                             | events.temp_poll;
    ev[mcei_pkg::SRC_ARCH]   = arch_chg;
    ev[mcei_pkg::SRC_PHY]    = events.phy_req;
  end

  // flag cells
  for (genvar i = 0; i < N; i++) begin : g_cell
    mcei_flag_cell u_cell (
      .pclk    (pclk),
      .presetn (presetn),
      .event_i (ev[i]),
      .clr_int (clr_int[i]),
      .clr_ofl (clr_ofl[i]),
      .int_d   (int_d[i]),
      .int_q   (int_q[i]),
      .ofl_d   (ofl_d[i]),
      .ofl_q   (ofl_q[i])
    );
  end

  // combined outputs use next values so they never lag the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comb_int_q <= 1'b0;
    end else begin
      comb_int_q <= |int_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comb_ofl_q <= 1'b0;
    end else begin
      comb_ofl_q <= |ofl_d;
    end
  end

  // mask applies from the cycle after its write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(int_d & mask_q);
    end
  end

  // apb slave
  assign acc     = req.psel & req.penable;
  assign wr_fire = acc & pready_q & req.pwrite;

  always_comb begin
    hit    = 1'b1;
    rd_mux = mcei_pkg::RST_RDATA;
    case (req.paddr)
      mcei_pkg::OFF_INT_STATUS: begin
        rd_mux[N-1:0] = int_q;
      end
      mcei_pkg::OFF_OFL_STATUS: begin
        rd_mux[N-1:0] = ofl_q;
      end
      mcei_pkg::OFF_INT_MASK: begin
        rd_mux[N-1:0] = mask_q;
      end
      mcei_pkg::OFF_ARCH_STATE: begin
        rd_mux[mcei_pkg::ARCH_W-1:0] = arch_q;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // write-one-to-clear strobes, only at the completing edge
  always_comb begin
    clr_int = '0;
    clr_ofl = '0;
    if (wr_fire && req.paddr == mcei_pkg::OFF_INT_STATUS) begin
      clr_int = req.pwdata[N-1:0];
    end
    if (wr_fire && req.paddr == mcei_pkg::OFF_OFL_STATUS) begin
      clr_ofl = req.pwdata[N-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= mcei_pkg::RST_MASK;
    end else if (wr_fire && req.paddr == mcei_pkg::OFF_INT_MASK) begin
      mask_q <= req.pwdata[N-1:0];
    end
  end

  // one wait state: keeps prdata and pslverr straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= mcei_pkg::RST_RDATA;
    end else if (acc && !pready_q) begin
      pready_q  <= 1'b1;
      pslverr_q <= ~hit;
      prdata_q  <= req.pwrite ? mcei_pkg::RST_RDATA : rd_mux;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= mcei_pkg::RST_RDATA;
    end
  end

  // port drive
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

  assign ram_ecc_errc_int      = int_q[mcei_pkg::SRC_RAM_C];
  assign ram_ecc_errd_int      = int_q[mcei_pkg::SRC_RAM_D];
  assign dram_ecc_errc_int     = int_q[mcei_pkg::SRC_DRAM_C];
  assign dram_ecc_errd_int     = int_q[mcei_pkg::SRC_DRAM_D];
  assign failed_access_int     = int_q[mcei_pkg::SRC_ACCESS];
  assign failed_prog_int       = int_q[mcei_pkg::SRC_PROG];
  assign link_err_int          = int_q[mcei_pkg::SRC_LINK];
  assign temperature_event_int = int_q[mcei_pkg::SRC_TEMP];
  assign arch_fsm_int          = int_q[mcei_pkg::SRC_ARCH];
  assign phy_request_int       = int_q[mcei_pkg::SRC_PHY];
  assign combined_int          = comb_int_q;

  assign ram_ecc_errc_oflow      = ofl_q[mcei_pkg::SRC_RAM_C];
  assign ram_ecc_errd_oflow      = ofl_q[mcei_pkg::SRC_RAM_D];
  assign dram_ecc_errc_oflow     = ofl_q[mcei_pkg::SRC_DRAM_C];
  assign dram_ecc_errd_oflow     = ofl_q[mcei_pkg::SRC_DRAM_D];
  assign failed_access_oflow     = ofl_q[mcei_pkg::SRC_ACCESS];
  assign failed_prog_oflow       = ofl_q[mcei_pkg::SRC_PROG];
  assign link_err_oflow          = ofl_q[mcei_pkg::SRC_LINK];
  assign temperature_event_oflow = ofl_q[mcei_pkg::SRC_TEMP];
  assign arch_fsm_oflow          = ofl_q[mcei_pkg::SRC_ARCH];
  assign phy_request_oflow       = ofl_q[mcei_pkg::SRC_PHY];
  assign combined_oflow          = comb_ofl_q;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_acc_wait;
    psel && penable && !pready;
  endsequence

  sequence s_acc_done;
    pready ##1 !pready;
  endsequence

  apb_answer_a: // APB timing
    assert property (s_acc_wait |=> s_acc_done)
    else $error("apb answer not one cycle into access");

  // answer code follows the address decode of the access cycle
  sequence s_acc_bad;
    psel && penable && !pready && !hit;
  endsequence

  apb_error_a: // unmapped address
    assert property (s_acc_bad |=> pready && pslverr)
    else $error("unmapped access answered without error");

  apb_okay_a: // mapped address
    assert property (psel && penable && !pready && hit |=> pready && !pslverr)
    else $error("mapped access answered with error");

  rdata_idle_a: // read data only with pready
    assert property (!pready |-> prdata == mcei_pkg::RST_RDATA)
    else $error("read data outside answer cycle");

  mask_write_a: // mask takes written bits
    assert property (wr_fire && req.paddr == mcei_pkg::OFF_INT_MASK
                     |=> mask_q == $past(req.pwdata[N-1:0]))
    else $error("mask write lost");

  // a set meeting its clear in one cycle wins in both flags
  for (genvar k = 0; k < N; k++) begin : g_chk
    src_set_a:
      assert property (ev[k] |=> int_q[k] && combined_int)
      else $error("event did not raise its interrupt");
    int_clear_a:
      assert property (clr_int[k] && !ev[k] |=> !int_q[k])
      else $error("interrupt clear not honoured");
    int_hold_a:
      assert property (int_q[k] && !clr_int[k] |=> int_q[k])
      else $error("interrupt dropped without clear");
    ofl_set_a:
      assert property (ev[k] && int_q[k] && !clr_int[k] |=> ofl_q[k])
      else $error("recurrence did not raise overflow");
    ofl_hold_a:
      assert property (ofl_q[k] && !clr_ofl[k] |=> ofl_q[k])
      else $error("overflow dropped without clear");
    ofl_clear_a:
      assert property (clr_ofl[k] && !(ev[k] && int_q[k] && !clr_int[k])
                       |=> !ofl_q[k])
      else $error("overflow clear not honoured");
  end

  comb_int_a:
    assert property (combined_int == (|int_q))
    else $error("combined interrupt differs from OR");

  comb_ofl_a:
    assert property (combined_oflow == (|ofl_q))
    else $error("combined overflow differs from OR");

  arch_change_a:
    assert property (arch_valid_q && !$stable(arch_state) |=> arch_fsm_int)
    else $error("state change missed");

  irq_mask_a: // masked summary
    assert property (irq == (|(int_q & $past(mask_q))))
    else $error("irq does not follow masked flags");

endmodule // mcei_top
`default_nettype wire

/* File: tb/mcei_host_model.sv */
// Purpose: far-side interrupt controller seen by the event block
// Assumes: level-sensitive irq input sampled on pclk
// Notes:   counts irq assertions so the bench can see deliveries
`timescale 1ns/100ps
`default_nettype none
module mcei_host_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // interrupt line
  input  wire logic       irq,
  // observed deliveries
  output var  logic [7:0] irq_edges
);
  logic irq_q;

  // level input, so only a low-to-high step is a new delivery
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q     <= 1'b0;
      irq_edges <= 8'h00;
    end else begin
      irq_q <= irq;
      if (irq && !irq_q) begin
        irq_edges <= irq_edges + 8'h01;
      end
    end
  end
endmodule // mcei_host_model
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench of the event interrupt block
// Assumes: apb answers after a wait state, events are one-cycle pulses except in wr_ev
// Notes:   one task per scenario, verdict printed by give_verdict
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic                     pclk, presetn, psel, penable, pwrite;
  logic [11:0]              paddr;
  logic [31:0]              pwdata;
  logic [3:0]               arch_state;
  mcei_pkg::mcei_event_type events;
  wire logic [31:0]         prdata;
  wire logic                pready, pslverr, cint, coflow, irq;
  wire logic [9:0]          ints, ofls;
  wire logic [7:0]          irq_edges;
  int                       miscompares = 0;
  int                       checks = 0;

  mcei_top mcei_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(events),
    .arch_state(arch_state),
    .ram_ecc_errc_int(ints[0]), .ram_ecc_errd_int(ints[1]),
    .dram_ecc_errc_int(ints[2]), .dram_ecc_errd_int(ints[3]),
    .failed_access_int(ints[4]), .failed_prog_int(ints[5]),
    .link_err_int(ints[6]), .temperature_event_int(ints[7]),
    .arch_fsm_int(ints[8]), .phy_request_int(ints[9]),
    .combined_int(cint),
    .ram_ecc_errc_oflow(ofls[0]), .ram_ecc_errd_oflow(ofls[1]),
    .dram_ecc_errc_oflow(ofls[2]), .dram_ecc_errd_oflow(ofls[3]),
    .failed_access_oflow(ofls[4]), .failed_prog_oflow(ofls[5]),
    .link_err_oflow(ofls[6]), .temperature_event_oflow(ofls[7]),
    .arch_fsm_oflow(ofls[8]), .phy_request_oflow(ofls[9]),
    .combined_oflow(coflow), .irq(irq)
  );

  mcei_host_model mcei_host_model_i (
    .pclk(pclk), .presetn(presetn), .irq(irq), .irq_edges(irq_edges)
  );

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic give_verdict();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // holds the request until pready is seen high at a rising edge;
  // only the watchdog ends a wait that never completes
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input logic experr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, experr});
  endtask

  // k 0..6 plain sources, 7 direct temp, 8 polled temp, 9 arch, 10 phy
  task automatic fire(input int k);
    @(posedge pclk);
    if (k < 7) events <= mcei_pkg::mcei_event_type'(10'h200 >> k);
    else if (k == 7) events <= mcei_pkg::mcei_event_type'(10'h004);
    else if (k == 8) events <= mcei_pkg::mcei_event_type'(10'h002);
    else if (k == 9) arch_state <= arch_state + 4'h1;
    else events <= mcei_pkg::mcei_event_type'(10'h001);
    @(posedge pclk);
    events <= mcei_pkg::mcei_event_type'(10'h000);
    #1;
  endtask

  task automatic test_reset();
    chk({22'h0, ints}, 32'h0000_0000);
    chk({22'h0, ofls}, 32'h0000_0000);
    rd(mcei_pkg::OFF_INT_STATUS, 32'h0000_0000, 1'b0);
    rd(mcei_pkg::OFF_OFL_STATUS, 32'h0000_0000, 1'b0);
    rd(mcei_pkg::OFF_INT_MASK, 32'h0000_0000, 1'b0);
    rd(mcei_pkg::OFF_ARCH_STATE, 32'h0000_0000, 1'b0);
    $display("test reset done");
  endtask

  task automatic test_bus();
    logic [31:0] r;
    logic        e;
    rd(12'h010, 32'h0000_0000, 1'b1);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF, r, e);
    chk({31'h0, e}, 32'h0000_0001);
    chk(r, 32'h0000_0000);
    wr(mcei_pkg::OFF_ARCH_STATE, 32'h0000_000F);
    rd(mcei_pkg::OFF_INT_MASK, 32'h0000_0000, 1'b0);
    rd(mcei_pkg::OFF_ARCH_STATE, {28'h0, arch_state}, 1'b0);
    $display("test bus done");
  endtask

  task automatic test_sources();
    logic [31:0] m;
    int          s;
    for (int k = 0; k < 11; k++) begin
      s = (k < 8) ? k : k - 1;
      if (k == 8) s = 7;
      m = 32'h0000_0001 << s;
      fire(k);
      chk({22'h0, ints}, m);
      chk({31'h0, cint}, 32'h0000_0001);
      rd(mcei_pkg::OFF_INT_STATUS, m, 1'b0);
      chk({22'h0, ints}, m);
      chk({22'h0, ofls}, 32'h0000_0000);
      fire(k);
      chk({22'h0, ofls}, m);
      chk({31'h0, coflow}, 32'h0000_0001);
      wr(mcei_pkg::OFF_OFL_STATUS, m);
      chk({22'h0, ofls}, 32'h0000_0000);
      chk({31'h0, coflow}, 32'h0000_0000);
      chk({22'h0, ints}, m);
      wr(mcei_pkg::OFF_INT_STATUS, m);
      chk({22'h0, ints}, 32'h0000_0000);
      chk({31'h0, cint}, 32'h0000_0000);
    end
    $display("test sources done");
  endtask

  task automatic test_irq();
    wr(mcei_pkg::OFF_INT_MASK, 32'h0000_0040);
    rd(mcei_pkg::OFF_INT_MASK, 32'h0000_0040, 1'b0);
    fire(0);
    repeat (2) @(posedge pclk);
    #1;
    chk({31'h0, irq}, 32'h0000_0000);
    chk({31'h0, cint}, 32'h0000_0001);
    fire(6);
    repeat (2) @(posedge pclk);
    #1;
    chk({31'h0, irq}, 32'h0000_0001);
    chk({24'h0, irq_edges}, 32'h0000_0001);
    wr(mcei_pkg::OFF_INT_MASK, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    #1;
    chk({31'h0, irq}, 32'h0000_0000);
    chk({22'h0, ints}, 32'h0000_0041);
    wr(mcei_pkg::OFF_INT_STATUS, 32'h0000_0041);
    chk({31'h0, cint}, 32'h0000_0000);
    $display("test irq done");
  endtask

  // write whose whole access phase carries an event, so the event
  // meets the clear strobe at the completing edge
  task automatic wr_ev(input logic [11:0] a, input logic [31:0] d,
                       input mcei_pkg::mcei_event_type ev);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= 1'b1;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    events  <= ev;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    events  <= mcei_pkg::mcei_event_type'(10'h000);
    #1;
  endtask

  // set wins over a clear in the same cycle
  task automatic test_collide();
    fire(2);
    fire(2);
    wr_ev(mcei_pkg::OFF_OFL_STATUS, 32'h0000_0004,
          mcei_pkg::mcei_event_type'(10'h080));
    chk({22'h0, ofls}, 32'h0000_0004);
    wr_ev(mcei_pkg::OFF_INT_STATUS, 32'h0000_0004,
          mcei_pkg::mcei_event_type'(10'h080));
    chk({22'h0, ints}, 32'h0000_0004);
    wr(mcei_pkg::OFF_OFL_STATUS, 32'h0000_0004);
    chk({22'h0, ofls}, 32'h0000_0000);
    wr(mcei_pkg::OFF_INT_STATUS, 32'h0000_0004);
    chk({22'h0, ints}, 32'h0000_0000);
    chk({31'h0, coflow}, 32'h0000_0000);
    $display("test collide done");
  endtask

  // whole run is a few hundred cycles; this is generous headroom
  initial begin
    #(40000 * 5);
    miscompares++;
    give_verdict();
  end

  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0000_0000;
    arch_state = 4'h0;
    events     = mcei_pkg::mcei_event_type'(10'h000);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    test_reset();
    test_bus();
    test_sources();
    test_irq();
    test_collide();
    give_verdict();
  end
endmodule // tb
`default_nettype wire
